/* File: rtl/ppm_pkg.sv */
/*
 * ppm_pkg: constants, register map and carriers of the pin mux.
 * Assumes a 32-bit AXI4-Lite bus and 8-bit ports.
 */
package ppm_pkg;
    // ------------------------------------------------------------------
    // port table, index order: p0 p1 p2 p4 p5 p6 p7 p8 p9 p10
    // ------------------------------------------------------------------
    localparam int NPORT = 10;
    localparam int PW    = 8;
    localparam logic [3:0] PI_P0 = 4'h0;
    localparam logic [3:0] PI_P1 = 4'h1;
    localparam logic [3:0] PI_P2 = 4'h2;
    localparam logic [3:0] PI_SEG0 = 4'h6;
    localparam logic [1:0] K_CMOS = 2'h0;
    localparam logic [1:0] K_IN   = 2'h1;
    localparam logic [1:0] K_NOD  = 2'h2;
    localparam logic [1:0] K_POD  = 2'h3;
    localparam logic [1:0] PORT_KIND [NPORT] = '{K_CMOS, K_IN, K_CMOS, K_CMOS, K_NOD,
                                                 K_NOD, K_POD, K_POD, K_POD, K_POD};
    localparam logic [7:0] PORT_MASK [NPORT] = '{8'h03, 8'hff, 8'h3f, 8'hff, 8'hff,
                                                 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0] DIR_MASK  [NPORT] = '{8'h03, 8'h00, 8'h3f, 8'hff, 8'hff,
                                                 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
    localparam logic [7:0] DIR_FORCE [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
    localparam logic [7:0] AUX_MASK  [NPORT] = '{8'h03, 8'h00, 8'h3f, 8'hff, 8'h00,
                                                 8'h00, 8'hff, 8'hff, 8'hff, 8'hff};
    // port2 bit roles
    localparam int B_SCK = 0;
    localparam int B_SO  = 1;
    localparam int B_SI  = 2;
    localparam int B_TI  = 3;
    localparam int B_TIO0 = 4;
    localparam int B_TIO1 = 5;
    // ------------------------------------------------------------------
    // register map: port table index n at n*0x10, words out/dir/aux/pin
    // ------------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [1:0] R_OUT = 2'h0;
    localparam logic [1:0] R_DIR = 2'h1;
    localparam logic [1:0] R_AUX = 2'h2;
    localparam logic [1:0] R_PIN = 2'h3;
    localparam logic [7:0] A_EDGE = 8'ha0;
    localparam logic [7:0] A_STAT = 8'ha4;
    localparam logic [7:0] A_MASK = 8'ha8;
    localparam logic [7:0] A_ALT  = 8'hac;
    localparam int ALT_SIO = 0;
    localparam int ALT_TO0 = 1;
    localparam int ALT_TO1 = 2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [3:0] RST_EDGE = 4'h0;
    localparam logic [1:0] RST_IRQ  = 2'h0;
    localparam logic [2:0] RST_ALT  = 3'h0;
    localparam logic [15:0] RST_SEG = 16'h0000;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } ppm_pin_drv_s;
    typedef struct packed {
        logic       sck_out;
        logic       sck_drive;
        logic       sdo;
        logic [1:0] pwm_out;
    } ppm_periph_s;
endpackage : ppm_pkg

/* File: rtl/ppm_port_mux.sv */
/*
 * ppm_port_mux: register file, pin drivers and alternate-function routing.
 * Assumes a pad ring that resolves pin levels from o, oe and pu.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - every I/O bit has own direction bit
// - pull-up only on input pins, ports 0/2/4
// - port 1 input only, feeds analog channels
// - external interrupts detect selected edge, request
// - external interrupts sampled from port 0 pins
// - port 2 bits 0-2 carry serial lines
// - port 2 bit 3 feeds remote timer
// - port 2 bits 4-5 PWM capture or output
// - segments 0-15 output only from display
// - ports 7-9 bitwise port or display output
// - ports 5/6 open drain, pull low only
// - shared pins reset as inputs, segments outputs
// - port 10 output only, display 40-47
module ppm_port_mux
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite slave
    input  wire logic [ppm_pkg::AW-1:0] s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    input  wire logic [ppm_pkg::AW-1:0] s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready,
    // port pins
    input  wire logic [7:0]            pin_in [ppm_pkg::NPORT],
    output ppm_pkg::ppm_pin_drv_s      pin_drv [ppm_pkg::NPORT],
    output logic [15:0]                dedicated_segment_outputs,
    // display controller and peripherals
    input  wire logic [15:0]           seg_ded_in,
    input  wire logic [7:0]            shared_segment_outputs [4],
    input  wire ppm_pkg::ppm_periph_s  periph,
    output logic                       sio_sck_in,
    output logic                       sio_sdi,
    output logic                       remote_timer_input,
    output logic [1:0]                 pwm_capture_in,
    output logic [7:0]                 analog_channel_inputs,
    output logic [1:0]                 ext_irq_req,
    output logic                       irq
);
    import ppm_pkg::*;

    logic [7:0]   out_r [NPORT], dir_r [NPORT], aux_r [NPORT], sy1_r [NPORT], sy2_r [NPORT];
    logic [1:0]   irq_prev_r, stat_r, mask_r, evt;
    logic [3:0]   edge_r;
    logic [2:0]   alt_r;
    logic [AW-1:0] awaddr_r;
    logic [7:0]   wdata_r;
    logic         aw_have_r, w_have_r, wlane_r, do_wr, wr_hit, rd_hit;
    ppm_pin_drv_s drv_nxt [NPORT];
    logic [31:0]  rd_nxt;
    // ------------------------------------------------------------------
    // axi write channels: address and data taken in either order
    // ------------------------------------------------------------------
    assign do_wr = aw_have_r && w_have_r && !s_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 8'h00;
            wlane_r   <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OK;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_awaddr;
            end
            if (s_wvalid && s_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= s_wdata[7:0];
                wlane_r  <= s_wstrb[0];
            end
            if (do_wr)
            begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_hit ? RESP_OK : RESP_ERR;
            end
            else if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
        end
    end

    // ready low while a word is held, so the master simply waits
    assign s_awready = !aw_have_r && aresetn;
    assign s_wready  = !w_have_r && aresetn;
    assign wr_hit    = (awaddr_r[7:4] < 4'(NPORT)) || (awaddr_r == A_EDGE) ||
                       (awaddr_r == A_STAT) || (awaddr_r == A_MASK) || (awaddr_r == A_ALT);

    // ------------------------------------------------------------------
    // port registers; only byte lane 0 carries data
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < NPORT; i++)
        begin
            if (!aresetn)
            begin
                out_r[i] <= RST_PORT;
                dir_r[i] <= RST_PORT;
                aux_r[i] <= RST_PORT;
            end
            else if (do_wr && wlane_r && awaddr_r[7:4] == 4'(i))
            begin
                if (awaddr_r[3:2] == R_OUT)
                    out_r[i] <= wdata_r & PORT_MASK[i];
                else if (awaddr_r[3:2] == R_DIR)
                    dir_r[i] <= wdata_r & DIR_MASK[i];
                else if (awaddr_r[3:2] == R_AUX)
                    aux_r[i] <= wdata_r & AUX_MASK[i];
            end
        end
    end

    // control registers: edge select, mask, alternate-function select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            edge_r <= RST_EDGE;
            mask_r <= RST_IRQ;
            alt_r  <= RST_ALT;
        end
        else if (do_wr && wlane_r)
        begin
            if (awaddr_r == A_EDGE)
                edge_r <= wdata_r[3:0];
            else if (awaddr_r == A_MASK)
                mask_r <= wdata_r[1:0];
            else if (awaddr_r == A_ALT)
                alt_r <= wdata_r[2:0];
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
        for (int i = 0; i < NPORT; i++)
        begin
            sy1_r[i] <= aresetn ? pin_in[i] & PORT_MASK[i] : 8'h00;
            sy2_r[i] <= aresetn ? sy1_r[i] : 8'h00;
        end
    // edge taken between second stage and its delayed copy, never stage one
    always_comb
        for (int k = 0; k < 2; k++)
            evt[k] = (edge_r[2*k] && sy2_r[PI_P0][k] && !irq_prev_r[k]) ||
                     (edge_r[2*k+1] && !sy2_r[PI_P0][k] && irq_prev_r[k]);
    // sticky status; a new edge wins over a write-one-to-clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_prev_r  <= RST_IRQ;
            stat_r      <= RST_IRQ;
            ext_irq_req <= RST_IRQ;
            irq         <= 1'b0;
        end
        else
        begin
            irq_prev_r  <= sy2_r[PI_P0][1:0];
            ext_irq_req <= evt;
            if (do_wr && wlane_r && awaddr_r == A_STAT)
                stat_r <= (stat_r & ~wdata_r[1:0]) | evt;
            else
                stat_r <= stat_r | evt;
            irq <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // pin drivers by port kind, then alternate-function overrides
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] de;
        logic [7:0] val;
        de  = 8'h00;
        val = 8'h00;
        for (int i = 0; i < NPORT; i++)
        begin
            de = (dir_r[i] & DIR_MASK[i]) | DIR_FORCE[i];
            drv_nxt[i] = '0;
            case (PORT_KIND[i])
                K_CMOS:
                begin
                    drv_nxt[i].o  = out_r[i];
                    drv_nxt[i].oe = de;
                    drv_nxt[i].pu = aux_r[i] & ~de;
                end
                K_NOD: drv_nxt[i].oe = de & ~out_r[i];
                K_POD:
                begin
                    // segment select takes the bit away from the latch
                    val = (aux_r[i] & shared_segment_outputs[i-PI_SEG0]) |
                          (~aux_r[i] & out_r[i]);
                    drv_nxt[i].o  = 8'hff;
                    drv_nxt[i].oe = (aux_r[i] | de) & val;
                end
                default: drv_nxt[i] = '0;
            endcase
        end
        if (alt_r[ALT_SIO])
        begin
            drv_nxt[PI_P2].o[B_SCK]  = periph.sck_out;
            drv_nxt[PI_P2].oe[B_SCK] = periph.sck_drive;
            drv_nxt[PI_P2].o[B_SO]   = periph.sdo;
            drv_nxt[PI_P2].oe[B_SO]  = 1'b1;
        end
        if (alt_r[ALT_TO0])
        begin
            drv_nxt[PI_P2].o[B_TIO0]  = periph.pwm_out[0];
            drv_nxt[PI_P2].oe[B_TIO0] = 1'b1;
        end
        if (alt_r[ALT_TO1])
        begin
            drv_nxt[PI_P2].o[B_TIO1]  = periph.pwm_out[1];
            drv_nxt[PI_P2].oe[B_TIO1] = 1'b1;
        end
        for (int i = 0; i < NPORT; i++)
        begin
            drv_nxt[i].oe = drv_nxt[i].oe & PORT_MASK[i];
            drv_nxt[i].pu = drv_nxt[i].pu & ~drv_nxt[i].oe;
        end
    end

    // registered pad drive; dedicated segments always drive
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < NPORT; i++)
            pin_drv[i] <= aresetn ? drv_nxt[i] : '0;
        dedicated_segment_outputs <= aresetn ? seg_ded_in : RST_SEG;
    end

    // peripheral inputs from the synchronised pin levels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sio_sck_in            <= 1'b0;
            sio_sdi               <= 1'b0;
            remote_timer_input    <= 1'b0;
            pwm_capture_in        <= 2'h0;
            analog_channel_inputs <= 8'h00;
        end
        else
        begin
            sio_sck_in            <= sy2_r[PI_P2][B_SCK];
            sio_sdi               <= sy2_r[PI_P2][B_SI];
            remote_timer_input    <= sy2_r[PI_P2][B_TI];
            pwm_capture_in        <= sy2_r[PI_P2][B_TIO1:B_TIO0];
            analog_channel_inputs <= sy2_r[PI_P1];
        end
    end

    // ------------------------------------------------------------------
    // read channel: one-cycle answer, unmapped reads zero with error
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [3:0] p;
        p      = s_araddr[7:4];
        rd_nxt = 32'h0000_0000;
        rd_hit = 1'b1;
        if (p < 4'(NPORT))
        begin
            if (s_araddr[3:2] == R_OUT)
                rd_nxt[7:0] = out_r[p];
            else if (s_araddr[3:2] == R_DIR)
                rd_nxt[7:0] = (dir_r[p] & DIR_MASK[p]) | DIR_FORCE[p];
            else if (s_araddr[3:2] == R_AUX)
                rd_nxt[7:0] = aux_r[p];
            else
                rd_nxt[7:0] = sy2_r[p];
        end
        else if (s_araddr == A_EDGE)
            rd_nxt[3:0] = edge_r;
        else if (s_araddr == A_STAT)
            rd_nxt[1:0] = stat_r;
        else if (s_araddr == A_MASK)
            rd_nxt[1:0] = mask_r;
        else if (s_araddr == A_ALT)
            rd_nxt[2:0] = alt_r;
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= RESP_OK;
        end
        else if (s_arvalid && s_arready)
        begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_nxt;
            s_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
        end
        else if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
    end

    assign s_arready = !s_rvalid && aresetn;
endmodule : ppm_port_mux
`default_nettype wire

/* File: verification/ppm_port_mux_assertions.sv */
/*
 * ppm_port_mux_assertions: concurrent checks on the ppm_port_mux ports.
 * Assumes one clock domain, aclk, with synchronous active-low aresetn.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_assertions
(
    // clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // pins and segments
    input wire logic [7:0]            pin_in [ppm_pkg::NPORT],
    input wire ppm_pkg::ppm_pin_drv_s pin_drv [ppm_pkg::NPORT],
    input wire logic [15:0]           dedicated_segment_outputs,
    input wire logic [15:0]           seg_ded_in,
    // routed inputs and requests
    input wire logic                  sio_sck_in,
    input wire logic                  sio_sdi,
    input wire logic                  remote_timer_input,
    input wire logic [1:0]            pwm_capture_in,
    input wire logic [7:0]            analog_channel_inputs,
    input wire logic [1:0]            ext_irq_req,
    input wire logic                  irq
);
    import ppm_pkg::*;
    logic [2:0] age_r;
    logic [7:0] oe_or;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since reset release; the sync chains need a few edges to fill
    always_ff @(posedge aclk)
        if (!aresetn)
            age_r <= 3'h0;
        else if (age_r != 3'h7)
            age_r <= age_r + 3'h1;
    // any pin driven at all
    always_comb
    begin
        oe_or = 8'h00;
        for (int i = 0; i < NPORT; i++)
            oe_or = oe_or | pin_drv[i].oe;
    end
    chk_seg_follow: assert property (age_r != 3'h0 |->
        dedicated_segment_outputs == $past(seg_ded_in)) else $error("seg path");
    chk_reset_inputs: assert property (age_r == 3'h0 |-> oe_or == 8'h00)
        else $error("driven at reset");
    chk_analog_noout: assert property (pin_drv[1].oe == 8'h00)
        else $error("analog driven");
    chk_analog_path: assert property (age_r >= 3'h5 |->
        analog_channel_inputs == $past(pin_in[1], 3)) else $error("analog route");
    chk_timer_route: assert property (age_r >= 3'h5 |->
        remote_timer_input == $past(pin_in[2][3], 3)) else $error("timer route");
    chk_capture_route: assert property (age_r >= 3'h5 |->
        pwm_capture_in == $past(pin_in[2][5:4], 3)) else $error("capture route");
    chk_serial_route: assert property (age_r >= 3'h5 |->
        {sio_sck_in, sio_sdi} == $past({pin_in[2][0], pin_in[2][2]}, 3)) else $error("serial");
    chk_irq0_cause: assert property (age_r == 3'h7 && ext_irq_req[0] |->
        $past(pin_in[0][0], 3) != $past(pin_in[0][0], 4)) else $error("irq0 no edge");
    chk_irq1_cause: assert property (age_r == 3'h7 && ext_irq_req[1] |->
        $past(pin_in[0][1], 3) != $past(pin_in[0][1], 4)) else $error("irq1 no edge");
    chk_drain_low: assert property (pin_drv[4].o == 8'h00 && pin_drv[5].o == 8'h00)
        else $error("drain high");
    chk_pull_input: assert property (((pin_drv[0].pu & pin_drv[0].oe) |
        (pin_drv[2].pu & pin_drv[2].oe) | (pin_drv[3].pu & pin_drv[3].oe)) == 8'h00)
        else $error("pull on output");
    cov_irq0: cover property (ext_irq_req[0]);
    cov_irq1: cover property (ext_irq_req[1]);
    cov_irq: cover property ($rose(irq));
    cov_alt: cover property (pin_drv[2].oe[1]);
endmodule : ppm_port_mux_assertions
`default_nettype wire

/* File: verification/ppm_board_model.sv */
/*
 * ppm_board_model: board circuitry on the port pins.
 * Assumes the bench sets ext to the level the board forces on free pins.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_board_model
(
    // design pin drivers
    input wire ppm_pkg::ppm_pin_drv_s pin_drv [ppm_pkg::NPORT],
    // board level on undriven pins
    input wire logic [7:0]            ext [ppm_pkg::NPORT],
    // resolved pin levels
    output logic [7:0]                pin_in [ppm_pkg::NPORT]
);
    import ppm_pkg::*;
    // open-drain kinds carry mask-option pulls, so ext cannot reach them
    always_comb
        for (int i = 0; i < NPORT; i++)
            pin_in[i] = (pin_drv[i].oe & pin_drv[i].o) | (~pin_drv[i].oe &
                ((PORT_KIND[i] == K_NOD) ? 8'hff : (PORT_KIND[i] == K_POD) ? 8'h00 :
                (pin_drv[i].pu | ext[i])));
endmodule : ppm_board_model
`default_nettype wire

/* File: verification/ppm_port_mux_tb_top.sv */
/*
 * ppm_port_mux_tb_top: self-checking bench for ppm_port_mux.
 * Assumes the board model resolves the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_tb_top;
    import ppm_pkg::*;
    logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, sio_sck_in, sio_sdi, remote_timer_input, irq;
    logic [7:0] s_awaddr, s_araddr, analog_channel_inputs;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, ext_irq_req, pwm_capture_in;
    logic [7:0] pin_in [NPORT], ext [NPORT], shared_segment_outputs [4];
    logic [15:0] seg_ded_in, dedicated_segment_outputs, seed;
    ppm_pin_drv_s pin_drv [NPORT];
    ppm_periph_s periph;
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int errors, n_tests, cyc, npulse [2];
    ppm_port_mux i_ppm_port_mux (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_in, .pin_drv,
        .dedicated_segment_outputs, .seg_ded_in, .shared_segment_outputs, .periph, .sio_sck_in,
        .sio_sdi, .remote_timer_input, .pwm_capture_in, .analog_channel_inputs, .ext_irq_req, .irq);
    ppm_board_model i_ppm_board_model (.pin_drv, .ext, .pin_in);
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] ra(input int p, input logic [1:0] r);
        return {p[3:0], r, 2'h0};
    endfunction : ra
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // axi write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= {24'h0, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && s_awready)
            begin
                ad = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!wd && s_wready)
            begin
                wd = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_bvalid);
        s_bready <= 1'b0;
    endtask : wr
    // axi read: the monitor compares the answer against the queued note
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        rq.push_back({r, 24'h0, d});
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        while (!s_rvalid) @(posedge aclk);
        s_rready <= 1'b0;
    endtask : rd
    // random latch, direction and aux on one port, then drivers and pin level
    task automatic port_case(input int i);
        logic [7:0] o, d, x, dx, sh, eoe, eo, pu, pl;
        seed = lfsr(seed);
        o = seed[7:0];
        d = seed[15:8];
        seed = lfsr(seed);
        x = seed[7:0];
        sh = seed[15:8];
        ext[i] <= seed[11:4] & PORT_MASK[i];
        if (i >= 6)
            shared_segment_outputs[i - 6] <= sh;
        wr(ra(i, R_OUT), o, RESP_OK);
        wr(ra(i, R_DIR), d, RESP_OK);
        wr(ra(i, R_AUX), x, RESP_OK);
        dx = (d & DIR_MASK[i]) | DIR_FORCE[i];
        x = x & AUX_MASK[i];
        pu = (PORT_KIND[i] == K_CMOS) ? x & ~dx : 8'h00;
        case (PORT_KIND[i])
            K_NOD: {eoe, eo, pl} = {dx & ~o, 8'h00, 8'hff};
            K_POD: {eoe, eo, pl} = {(dx | x) & ((x & sh) | (~x & o)), 8'hff, 8'h00};
            default: {eoe, eo, pl} = {dx & PORT_MASK[i], o, pu | (seed[11:4] & PORT_MASK[i])};
        endcase
        repeat (4) @(posedge aclk);
        chk({26'h0, pin_drv[i].oe}, {26'h0, eoe});
        chk({26'h0, pin_drv[i].o & eoe}, {26'h0, eo & eoe});
        chk({26'h0, pin_drv[i].pu}, {26'h0, pu});
        rd(ra(i, R_PIN), ((eoe & eo) | (~eoe & pl)) & PORT_MASK[i], RESP_OK);
        rd(ra(i, R_DIR), dx, RESP_OK);
        rd(ra(i, R_AUX), x, RESP_OK);
    endtask : port_case
    // ----------------------------------------------------------------
    // monitor: answers, interrupt pulses, segment stimulus, timeout
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (s_rvalid && s_rready)
            chk({s_rresp, s_rdata}, rq.pop_front());
        if (s_bvalid && s_bready)
            chk({32'h0, s_bresp}, {32'h0, bq.pop_front()});
        npulse[0] += int'(ext_irq_req[0]);
        npulse[1] += int'(ext_irq_req[1]);
        seg_ded_in <= seed ^ cyc[15:0];
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, seg_ded_in, periph} = {48'h0, 4'hf, 21'h0};
        {errors, n_tests, cyc, npulse[0], npulse[1]} = '0;
        seed = 16'd28837;
        ext = '{default: 8'h00};
        shared_segment_outputs = '{default: 8'h00};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < NPORT; i++)
        begin
            rd(ra(i, R_OUT), 8'h00, RESP_OK);
            rd(ra(i, R_DIR), DIR_FORCE[i], RESP_OK);
        end
        rd(8'hb0, 8'h00, RESP_ERR);
        wr(8'hb0, 8'h5a, RESP_ERR);
        repeat (4)
            for (int i = 0; i < NPORT; i++)
                port_case(i);
        // edge detection on port0 pins, edge modes 1-3 on both inputs
        wr(ra(0, R_DIR), 8'h00, RESP_OK);
        wr(ra(0, R_AUX), 8'h00, RESP_OK);
        ext[0] <= 8'h00;
        for (int k = 0; k < 2; k++)
            for (int m = 1; m < 4; m++)
            begin
                int n0;
                wr(A_EDGE, 8'(m << (2 * k)), RESP_OK);
                n0 = npulse[k];
                ext[0][k] <= 1'b1;
                repeat (8) @(posedge aclk);
                ext[0][k] <= 1'b0;
                repeat (8) @(posedge aclk);
                chk(34'(npulse[k] - n0), 34'((m & 1) + (m >> 1)));
                rd(A_STAT, 8'(1 << k), RESP_OK);
                chk({33'h0, irq}, 34'h0);
                wr(A_MASK, 8'(1 << k), RESP_OK);
                repeat (3) @(posedge aclk);
                chk({33'h0, irq}, 34'h1);
                wr(A_STAT, 8'(1 << k), RESP_OK);
                wr(A_MASK, 8'h00, RESP_OK);
                repeat (3) @(posedge aclk);
                chk({33'h0, irq}, 34'h0);
            end
        // alternate outputs on port2 replace the latch, pin still readable
        wr(ra(2, R_DIR), 8'h00, RESP_OK);
        wr(ra(2, R_AUX), 8'h00, RESP_OK);
        wr(A_ALT, 8'h07, RESP_OK);
        repeat (4)
        begin
            seed = lfsr(seed);
            periph <= seed[4:0];
            ext[2] <= seed[15:8] & 8'h3f;
            repeat (3) @(posedge aclk);
            chk({28'h0, pin_drv[2].oe[5:4], pin_drv[2].oe[1], pin_drv[2].o[5:4], pin_drv[2].o[1]},
                {28'h0, 3'h7, periph.pwm_out, periph.sdo});
            chk({33'h0, pin_drv[2].oe[0]}, {33'h0, periph.sck_drive});
            rd(ra(2, R_PIN), {2'h0, periph.pwm_out, seed[11:10], periph.sdo,
                periph.sck_drive ? periph.sck_out : seed[8]}, RESP_OK);
        end
        wr(A_ALT, 8'h00, RESP_OK);
        repeat (3) @(posedge aclk);
        chk({26'h0, pin_drv[2].oe}, 34'h0);
        tally_and_finish();
    end
endmodule : ppm_port_mux_tb_top
bind ppm_port_mux ppm_port_mux_assertions i_ppm_port_mux_assertions (.aclk, .aresetn, .pin_in,
    .pin_drv, .dedicated_segment_outputs, .seg_ded_in, .sio_sck_in, .sio_sdi, .remote_timer_input,
    .pwm_capture_in, .analog_channel_inputs, .ext_irq_req, .irq);
`default_nettype wire
